// >>> verification/pll_ctrl_monitor.sv
// Port checker of the PLL control block
`timescale 1ns/10ps
`default_nettype none

module pll_ctrl_monitor (
  input wire logic        clk_sys,               // Clock
  input wire logic        reset_n,               // Reset
  input wire logic [17:0] address,               // Address
  input wire logic        read,                  // Read
  input wire logic        write,                 // Write
  input wire logic [3:0]  byteenable,            // Lanes
  input wire logic [31:0] writedata,             // Write data
  input wire logic [31:0] readdata,              // Read data
  input wire logic        waitrequest,           // Wait
  input wire logic        master_clock_pin,      // Master clock
  input wire logic        synth_clock_run,       // PLL clock running
  input wire logic        synth_lock,            // Lock flag
  input wire logic        core_clock_source_sel, // Core source
  input wire logic [15:0] synth_feedback_active, // Feedback
  input wire logic        clock_out_pin_o,       // Clock-out value
  input wire logic        clock_out_pin_oe       // Clock-out enable
);
  int   gap;
  logic pin_q;

  // Cycles since the master clock pin last moved
  always_ff @(posedge clk_sys) begin
    pin_q <= master_clock_pin;
    gap   <= (pin_q != master_clock_pin) ? 0 : ((gap < 1000) ? gap + 1 : gap);
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_run_off_stops: assert property (write && !waitrequest && address == 18'h3_c00c
    && byteenable[0] && !writedata[0] |-> ##2 !synth_clock_run)
    else $error("PLL clock runs after run bit cleared");
  a_lock_needs_setting: assert property (synth_lock |-> synth_feedback_active != 16'h0000)
    else $error("lock with zero feedback");
  a_lock_needs_ref: assert property (synth_lock |-> gap < 410)
    else $error("lock held without reference");
  a_reset_quiet: assert property ($rose(reset_n) |-> !synth_lock && !clock_out_pin_oe
    && !core_clock_source_sel && synth_feedback_active == 16'h0060)
    else $error("outputs not at reset values");
  a_lock_readback: assert property (read && !waitrequest && address == 18'h3_c010
    |-> readdata == {31'h0000_0000, $past(synth_lock)})
    else $error("lock status read wrong");
  a_source_on_run: assert property ($changed(core_clock_source_sel)
    |-> $past(write && !waitrequest && address == 18'h3_c00c, 2))
    else $error("source changed without run write");
  a_feedback_on_run: assert property ($changed(synth_feedback_active)
    |-> $past(write && !waitrequest && address == 18'h3_c00c, 2))
    else $error("feedback changed without run write");
  a_oe_on_run: assert property ($changed(clock_out_pin_oe)
    |-> $past(write && !waitrequest && address == 18'h3_c00c, 3))
    else $error("enable changed without run write");

  c_locked: cover property ($rose(synth_lock));
  c_drive: cover property ($rose(clock_out_pin_oe));
  c_lock_read: cover property (read && !waitrequest && address == 18'h3_c010 && readdata[0]);
endmodule : pll_ctrl_monitor

bind pll_enable_lock_clock_out_pin_ctrl pll_ctrl_monitor mon_u (.clk_sys, .reset_n, .address, .read,
  .write, .byteenable, .writedata, .readdata, .waitrequest, .master_clock_pin, .synth_clock_run,
  .synth_lock, .core_clock_source_sel, .synth_feedback_active, .clock_out_pin_o,
  .clock_out_pin_oe);

`default_nettype wire

// >>> verification/pll_enable_lock_clock_out_pin_ctrl_tb_top.sv
// Testbench of the PLL control block
`timescale 1ns/10ps
`default_nettype none
`include "pll_ctrl_map.svh"

module pll_enable_lock_clock_out_pin_ctrl_tb_top;
  logic        clk_sys = 0, reset_n = 0, read = 0, write = 0, mclk_on = 1, master_clock_pin = 0;
  logic [17:0] address = '0;
  logic [31:0] writedata = '0, readdata;
  logic        waitrequest, synth_clock_run, synth_lock, core_clock_source_sel;
  logic        clock_out_pin_o, clock_out_pin_oe;
  logic [15:0] synth_feedback_active, rd;
  logic [15:0] rst_tbl [7] = '{16'h0060, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [4:0]  mcnt = '0;
  int          num_errors = 0, samples_checked = 0, edges;
  logic [3:0]  byteenable = 4'h3;

  pll_enable_lock_clock_out_pin_ctrl dut_u (.clk_sys, .reset_n, .address, .read, .write, .byteenable,
    .writedata, .readdata, .waitrequest, .master_clock_pin, .synth_clock_run, .synth_lock,
    .core_clock_source_sel, .synth_feedback_active, .clock_out_pin_o, .clock_out_pin_oe);

  // Clock, 10 ns period
  always #5 clk_sys = ~clk_sys;

  // Master clock, 32 system cycles a period
  always @(posedge clk_sys) begin
    if (mclk_on) begin
      mcnt <= mcnt + 5'h01;
      master_clock_pin <= mcnt[4];
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus_write(input logic [15:0] idx, input logic [15:0] data);
    address <= {idx, 2'b00};
    writedata <= {16'h0000, data};
    write <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (waitrequest !== 1'b0);
    write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus_write

  task automatic bus_read(input logic [15:0] idx, output logic [15:0] data);
    address <= {idx, 2'b00};
    read <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (waitrequest !== 1'b0);
    data = readdata[15:0];
    read <= 1'b0;
    @(posedge clk_sys);
  endtask : bus_read

  // Stage settings and reload them with a run bit rise
  task automatic configure(input logic [1:0] pre, input logic [1:0] rate, input logic drive);
    bus_write(`IDX_SYNTH_RUN_CTRL, 16'h0000);
    bus_write(`IDX_PRESCALE, {14'h0000, pre});
    bus_write(`IDX_CLOCK_OUT_CTRL, {13'h0000, rate, drive});
    bus_write(`IDX_SYNTH_RUN_CTRL, 16'h0001);
  endtask : configure

  task automatic poll_lock();
    int n = 0;
    do begin
      bus_read(`IDX_SYNTH_LOCK_STATUS, rd);
      n++;
    end while (rd[0] !== 1'b1 && n < 2000);
  endtask : poll_lock

  task automatic print_verdict();
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 7; i++) begin
      bus_read(16'(`IDX_SYNTH_FEEDBACK + i), rd);
      check(rd, rst_tbl[i]);
    end
    bus_write(`IDX_SYNTH_LOCK_STATUS, 16'hffff);
    bus_read(`IDX_SYNTH_LOCK_STATUS, rd);
    check(rd, 0);
    bus_write(`IDX_CORE_CLOCK_SOURCE, 16'h0001);
    bus_write(`IDX_CLOCK_OUT_CTRL, 16'h0001);
    repeat (700) @(posedge clk_sys);
    check(synth_lock, 0);
    check(synth_clock_run, 0);
    check({core_clock_source_sel, clock_out_pin_oe}, 0);
    bus_write(`IDX_SYNTH_RUN_CTRL, 16'h0001);
    repeat (3) @(posedge clk_sys);
    check(core_clock_source_sel, 1);
    check(clock_out_pin_oe, 1);
    poll_lock();
    check(rd, 1);
    check(synth_clock_run, 1);
    // Every rate code, then each slower prescale code
    for (int r = 0; r < 7; r++) begin
      int pre;
      pre = (r < 4) ? 0 : r - 3;
      configure(2'(pre), 2'((r < 4) ? r : 3), 1'b1);
      repeat (600) @(posedge clk_sys);
      edges = 0;
      repeat (512) begin
        rd[1] = clock_out_pin_o;
        @(posedge clk_sys);
        if (rd[1] === 1'b0 && clock_out_pin_o === 1'b1) edges++;
      end
      check(edges, (16 >> pre) << ((r < 4) ? r : 3));
    end
    configure(2'd0, 2'd0, 1'b0);
    repeat (3) @(posedge clk_sys);
    check(clock_out_pin_oe, 0);
    poll_lock();
    check(rd, 1);
    bus_write(`IDX_SYNTH_RUN_CTRL, 16'h0000);
    repeat (2) @(posedge clk_sys);
    check(synth_lock, 0);
    check(synth_clock_run, 0);
    bus_write(`IDX_SYNTH_FEEDBACK, 16'h0000);
    bus_write(`IDX_SYNTH_RUN_CTRL, 16'h0001);
    repeat (2500) @(posedge clk_sys);
    check(synth_feedback_active, 0);
    check(synth_lock, 0);
    bus_write(`IDX_SYNTH_RUN_CTRL, 16'h0000);
    bus_write(`IDX_SYNTH_FEEDBACK, 16'h0060);
    bus_write(`IDX_SYNTH_RUN_CTRL, 16'h0001);
    poll_lock();
    check(rd, 1);
    mclk_on <= 1'b0;
    repeat (500) @(posedge clk_sys);
    check(synth_lock, 0);
    check(synth_clock_run, 0);
    print_verdict();
  end
endmodule : pll_enable_lock_clock_out_pin_ctrl_tb_top

`default_nettype wire

// >>> verilog/clock_out_gen.sv
// Clock-out generator: multiplies the prescaled reference by 1, 2, 4 or 8
`timescale 1ns/10ps
`default_nettype none

module clock_out_gen (
  input  wire logic       clk_sys,        // System clock
  input  wire logic       reset_n,        // Synchronous reset, active low
  input  wire logic       ref_tick,       // One pulse per prescaled reference period
  input  wire logic [1:0] rate_sel,       // Multiply code 00..11
  input  wire logic       drive_en,       // Drive the pin when high
  output logic            clock_out_o,    // Clock-out pin output value
  output logic            clock_out_oe    // Clock-out pin output enable
);

  logic [15:0] period_cnt;
  logic [15:0] period;
  logic [15:0] half_cnt;
  logic [15:0] half;
  logic [2:0]  shift_amt;

  // Shift of 1..4; three bits so code 11 does not wrap to zero
  assign shift_amt = {1'b0, rate_sel} + 3'd1;

  // Half period of the output: reference period over twice the factor
  assign half = (period >> shift_amt) == 16'h0000 ? 16'h0001
              : (period >> shift_amt);

  // Measure reference period in system cycles
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      period_cnt <= 16'h0001;
      period     <= 16'h0000;
    end else if (ref_tick) begin
      period_cnt <= 16'h0001;
      period     <= period_cnt;
    end else if (period_cnt != 16'hffff) begin
      period_cnt <= period_cnt + 16'h0001;
    end
  end

  // Toggle output every half period, realigned on each reference edge
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      half_cnt    <= 16'h0000;
      clock_out_o <= 1'b0;
    end else if (period == 16'h0000) begin
      half_cnt    <= 16'h0000;
      clock_out_o <= 1'b0;
    end else if (ref_tick) begin
      half_cnt    <= 16'h0001;
      clock_out_o <= 1'b1;
    end else if (half_cnt >= half) begin
      half_cnt    <= 16'h0001;
      clock_out_o <= ~clock_out_o;
    end else begin
      half_cnt    <= half_cnt + 16'h0001;
    end
  end

  // Pin released to high impedance when not enabled
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      clock_out_oe <= 1'b0;
    end else begin
      clock_out_oe <= drive_en;
    end
  end

endmodule : clock_out_gen

`default_nettype wire

// >>> verilog/pll_ctrl_map.svh
// Register offsets, field positions, reset values and timing counts of the PLL control block
`ifndef PLL_CTRL_MAP_SVH
`define PLL_CTRL_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_SYNTH_FEEDBACK    16'hf000
`define IDX_PRESCALE          16'hf001
`define IDX_CORE_CLOCK_SOURCE 16'hf002
`define IDX_SYNTH_RUN_CTRL    16'hf003
`define IDX_SYNTH_LOCK_STATUS 16'hf004
`define IDX_CLOCK_OUT_CTRL    16'hf005

// Reset values
`define RST_SYNTH_FEEDBACK    16'h0060
`define RST_PRESCALE          16'h0000
`define RST_CORE_CLOCK_SOURCE 16'h0000
`define RST_SYNTH_RUN_CTRL    16'h0000
`define RST_CLOCK_OUT_CTRL    16'h0000

// Field positions
`define BIT_SYNTH_RUN         0
`define BIT_SYNTH_LOCK        0
`define BIT_CORE_CLOCK_SOURCE 0
`define MSB_PRESCALE          1
`define LSB_PRESCALE          0
`define BIT_CLOCK_OUT_DRIVE   0
`define MSB_CLOCK_OUT_RATE    2
`define LSB_CLOCK_OUT_RATE    1

// Timing: system clock period, reference timeout, settle length
`define SYS_CLK_PERIOD_NS     10
`define REF_TIMEOUT_NS        4000
`define REF_TIMEOUT_CYCLES    (`REF_TIMEOUT_NS / `SYS_CLK_PERIOD_NS)
`define SETTLE_REF_TICKS      16'h0040

`endif

// >>> verilog/pll_ctrl_pkg.sv
// Types shared by the PLL control block
package pll_ctrl_pkg;

  // Lock sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_ACQUIRE = 3'b010,
    ST_LOCKED  = 3'b100
  } lock_state_t;

endpackage : pll_ctrl_pkg

// >>> verilog/pll_enable_lock_clock_out_pin_ctrl.sv
// PLL enable, lock status and clock-out control with Avalon-MM register slave
// Operation
// - No lock attempt starts until software sets the run bit to one.
// - With the run bit at zero there is no PLL output clock and PLL-fed logic idles.
// - Writes to feedback, prescale, source and clock-out registers wait until run rises.
// - Lock needs a stable reference, valid settings, run at one and a settled loop.
// - Lock status bit 0 is read-only, 1 means locked, and it is 0 after reset.
// - Clock-out rate code 00..11 at bits 2:1 selects the reference times 1, 2, 4 or 8.
// - Clock-out frequency scales in proportion with the master clock.
// - Clock-out drive enable at bit 0 drives the pin, else the pin floats.
// - Prescale code 00..11 divides the master clock by 1, 2, 4 or 8.
// - Core clock source select routes master clock at 0 and PLL output at 1.
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pll_ctrl_map.svh"

module pll_enable_lock_clock_out_pin_ctrl (
  input  wire logic        clk_sys,               // System clock, 100 MHz
  input  wire logic        reset_n,               // Synchronous reset, active low
  input  wire logic [17:0] address,               // Avalon byte address
  input  wire logic        read,                  // Avalon read request
  input  wire logic        write,                 // Avalon write request
  input  wire logic [3:0]  byteenable,            // Avalon byte enables
  input  wire logic [31:0] writedata,             // Avalon write data
  output logic      [31:0] readdata,              // Avalon read data
  output logic             waitrequest,           // Avalon wait request
  input  wire logic        master_clock_pin,      // External master clock, asynchronous
  output logic             synth_clock_run,       // PLL output clock running
  output logic             synth_lock,            // Lock flag
  output logic             core_clock_source_sel, // Core clock mux: 1 PLL, 0 master pin
  output logic [15:0]      synth_feedback_active, // Active feedback setting
  output logic             clock_out_pin_o,       // Clock-out pin value
  output logic             clock_out_pin_oe       // Clock-out pin output enable
);

  localparam logic [15:0] REF_TIMEOUT  = 16'(`REF_TIMEOUT_CYCLES);
  localparam logic [15:0] PRESCALE_RST = `RST_PRESCALE;
  localparam logic [15:0] SOURCE_RST   = `RST_CORE_CLOCK_SOURCE;
  localparam logic [15:0] CLOCK_OUT_PIN_RST   = `RST_CLOCK_OUT_CTRL;

  logic        ack;
  logic [15:0] word_idx;
  logic        wr_go;
  logic        lane0;
  logic        lane1;
  logic [15:0] next_wval;
  logic [15:0] feedback_pend;
  logic [15:0] prescale_pend;
  logic [15:0] source_pend;
  logic [15:0] run_reg;
  logic [15:0] clock_out_pin_pend;
  logic [1:0]  prescale_act;
  logic [2:0]  clock_out_pin_act;
  logic        run_prev;
  logic        run_rise;
  logic        mclk_s1;
  logic        mclk_s2;
  logic        mclk_s3;
  logic        mclk_rise;
  logic [2:0]  pre_cnt;
  logic [2:0]  pre_last;
  logic        ref_tick;
  logic [15:0] gap_cnt;
  logic        ref_stable;
  logic        settings_ok;
  logic [15:0] settle_cnt;
  pll_ctrl_pkg::lock_state_t state;
  pll_ctrl_pkg::lock_state_t next_state;

  // Bus decode: one wait cycle, then the access completes
  assign word_idx    = address[17:2];
  assign waitrequest = (read | write) & ~ack;
  assign wr_go       = write & ack;
  assign lane0       = byteenable[0];
  assign lane1       = byteenable[1];

  // Acknowledge pulse for every request
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (read | write) & ~ack;
    end
  end

  // Byte-lane merge helper for 16-bit registers
  function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [31:0] wd,
                                        input logic b0, input logic b1);
    merge = {b1 ? wd[15:8] : old_v[15:8], b0 ? wd[7:0] : old_v[7:0]};
  endfunction : merge

  // Register writes; all but run_reg held until run rises
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      feedback_pend <= `RST_SYNTH_FEEDBACK;
      prescale_pend <= `RST_PRESCALE;
      source_pend   <= `RST_CORE_CLOCK_SOURCE;
      run_reg       <= `RST_SYNTH_RUN_CTRL;
      clock_out_pin_pend   <= `RST_CLOCK_OUT_CTRL;
    end else if (wr_go) begin
      case (word_idx)
        `IDX_SYNTH_FEEDBACK:    feedback_pend <= merge(feedback_pend, writedata, lane0, lane1);
        `IDX_PRESCALE:          prescale_pend <= merge(prescale_pend, writedata, lane0, lane1);
        `IDX_CORE_CLOCK_SOURCE: source_pend   <= merge(source_pend, writedata, lane0, lane1);
        `IDX_SYNTH_RUN_CTRL:    run_reg       <= merge(run_reg, writedata, lane0, lane1);
        `IDX_CLOCK_OUT_CTRL:    clock_out_pin_pend   <= merge(clock_out_pin_pend, writedata, lane0, lane1);
        default: ;
      endcase
    end
  end

  // Read data, captured in the wait cycle
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      readdata <= 32'h0000_0000;
    end else if (read & ~ack) begin
      case (word_idx)
        `IDX_SYNTH_FEEDBACK:    readdata <= {16'h0000, feedback_pend};
        `IDX_PRESCALE:          readdata <= {16'h0000, prescale_pend};
        `IDX_CORE_CLOCK_SOURCE: readdata <= {16'h0000, source_pend};
        `IDX_SYNTH_RUN_CTRL:    readdata <= {16'h0000, run_reg};
        `IDX_SYNTH_LOCK_STATUS: readdata <= {31'h0000_0000, synth_lock};
        `IDX_CLOCK_OUT_CTRL:    readdata <= {16'h0000, clock_out_pin_pend};
        default:                readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Run bit edge detect
  assign run_rise = run_reg[`BIT_SYNTH_RUN] & ~run_prev;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      run_prev <= 1'b0;
    end else begin
      run_prev <= run_reg[`BIT_SYNTH_RUN];
    end
  end

  // Copy pending settings into use on run rising edge
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      synth_feedback_active <= `RST_SYNTH_FEEDBACK;
      prescale_act          <= PRESCALE_RST[`MSB_PRESCALE:`LSB_PRESCALE];
      core_clock_source_sel <= SOURCE_RST[`BIT_CORE_CLOCK_SOURCE];
      clock_out_pin_act            <= CLOCK_OUT_PIN_RST[2:0];
    end else if (run_rise) begin
      synth_feedback_active <= feedback_pend;
      prescale_act          <= prescale_pend[`MSB_PRESCALE:`LSB_PRESCALE];
      core_clock_source_sel <= source_pend[`BIT_CORE_CLOCK_SOURCE];
      clock_out_pin_act            <= clock_out_pin_pend[2:0];
    end
  end

  // Master clock pin synchroniser and edge detect
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mclk_s1 <= 1'b0;
      mclk_s2 <= 1'b0;
      mclk_s3 <= 1'b0;
    end else begin
      mclk_s1 <= master_clock_pin;
      mclk_s2 <= mclk_s1;
      mclk_s3 <= mclk_s2;
    end
  end

  assign mclk_rise = mclk_s2 & ~mclk_s3;

  // Prescale divider: one reference tick per 1, 2, 4 or 8 master edges
  assign pre_last = 3'((4'h1 << prescale_act) - 4'h1);
  assign ref_tick = mclk_rise & (pre_cnt == pre_last);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pre_cnt <= 3'h0;
    end else if (mclk_rise) begin
      pre_cnt <= (pre_cnt >= pre_last) ? 3'h0 : pre_cnt + 3'h1;
    end
  end

  // Reference presence watch: stable while edges keep arriving
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      gap_cnt <= REF_TIMEOUT;
    end else if (mclk_rise) begin
      gap_cnt <= 16'h0000;
    end else if (gap_cnt != REF_TIMEOUT) begin
      gap_cnt <= gap_cnt + 16'h0001;
    end
  end

  assign ref_stable  = gap_cnt != REF_TIMEOUT;
  assign settings_ok = synth_feedback_active != 16'h0000;

  // Lock sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      pll_ctrl_pkg::ST_IDLE: begin
        if (run_reg[`BIT_SYNTH_RUN] && !run_rise && ref_stable && settings_ok) begin
          next_state = pll_ctrl_pkg::ST_ACQUIRE;
        end
      end
      pll_ctrl_pkg::ST_ACQUIRE: begin
        if (!run_reg[`BIT_SYNTH_RUN] || !ref_stable) begin
          next_state = pll_ctrl_pkg::ST_IDLE;
        end else if (ref_tick && settle_cnt == `SETTLE_REF_TICKS - 16'h0001) begin
          next_state = pll_ctrl_pkg::ST_LOCKED;
        end
      end
      pll_ctrl_pkg::ST_LOCKED: begin
        if (!run_reg[`BIT_SYNTH_RUN] || !ref_stable) begin
          next_state = pll_ctrl_pkg::ST_IDLE;
        end
      end
      default: next_state = pll_ctrl_pkg::ST_IDLE;
    endcase
  end

  // Lock sequencer state register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= pll_ctrl_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Settle counter in reference ticks
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      settle_cnt <= 16'h0000;
    end else if (state != pll_ctrl_pkg::ST_ACQUIRE) begin
      settle_cnt <= 16'h0000;
    end else if (ref_tick) begin
      settle_cnt <= settle_cnt + 16'h0001;
    end
  end

  // Lock flag and PLL output run, both zero while run bit is zero
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      synth_lock      <= 1'b0;
      synth_clock_run <= 1'b0;
    end else begin
      synth_lock      <= next_state == pll_ctrl_pkg::ST_LOCKED;
      synth_clock_run <= next_state == pll_ctrl_pkg::ST_LOCKED;
    end
  end

  // Clock-out generator from prescaled reference
  clock_out_gen u_clock_out_gen (
    .clk_sys      (clk_sys),
    .reset_n      (reset_n),
    .ref_tick     (ref_tick),
    .rate_sel     (clock_out_pin_act[`MSB_CLOCK_OUT_RATE:`LSB_CLOCK_OUT_RATE]),
    .drive_en     (clock_out_pin_act[`BIT_CLOCK_OUT_DRIVE]),
    .clock_out_o  (clock_out_pin_o),
    .clock_out_oe (clock_out_pin_oe)
  );

endmodule : pll_enable_lock_clock_out_pin_ctrl

`default_nettype wire
